// ==== pkg/hs_sup_pkg.sv ====
// Purpose: Shared constants and types of the hot-swap supervisor
// Assumes: 200 MHz clock, comparator results arrive as digital levels
// Notes:   Input bit positions are shared by the synchroniser and the core
package hs_sup_pkg;
  // Comparator input positions
  localparam int        IN_LOCK  = 0;
  localparam int        IN_UV    = 1;
  localparam int        IN_OV    = 2;
  localparam int        IN_OC    = 3;
  localparam int        IN_HF    = 4;
  localparam int        IN_DRAIN = 5;
  localparam int        IN_GATE  = 6;
  localparam int        N_IN     = 7;
  // Lockout starts asserted so nothing turns on before inputs settle
  localparam logic [6:0] SYNC_RST = 7'h01;

  // Timing
  localparam int CLK_FREQ_MHZ   = 200;
  localparam int OC_TIMEOUT_US  = 600;
  localparam int OC_TIMEOUT_CYC = OC_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int HF_OFF_US      = 10;
  localparam int HF_OFF_CYC     = HF_OFF_US * CLK_FREQ_MHZ;

  // Register map
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_TIMER  = 8'h08;
  localparam int         CTRL_POL   = 0;
  localparam logic       CTRL_RST   = 1'b0;

  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_ON    = 5'h02,
    ST_REG   = 5'h04,
    ST_HARD  = 5'h08,
    ST_LATCH = 5'h10
  } gate_st_t;
endpackage

// ==== pkg/cmp_sync_if.sv ====
// Purpose: Raw and cleaned comparator levels between synchroniser and core
// Assumes: One clock domain on the cleaned side
// Notes:   Raw side is asynchronous to mclk_i
`timescale 1ns/10ps
interface cmp_sync_if #(parameter int W = 7);
  logic [W-1:0] raw;
  logic [W-1:0] cln;
  modport sync (input raw, output cln);
  modport core (output raw, input cln);
endinterface

// ==== logic/cmp_sync.sv ====
// Purpose: Three-stage synchroniser bank for comparator levels
// Assumes: Inputs change slowly compared to the clock
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/10ps
module cmp_sync
  import hs_sup_pkg::*;
#(
  parameter int         W   = N_IN,
  parameter logic [6:0] RST = SYNC_RST
) (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  cmp_sync_if.sync  s
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] cln_ff;

  assign s.cln = cln_ff;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          s1_ff[g]  <= RST[g];
          s2_ff[g]  <= RST[g];
          s3_ff[g]  <= RST[g];
          cln_ff[g] <= RST[g];
        end else begin
          s1_ff[g] <= s.raw[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (s2_ff[g] == s3_ff[g]) begin
            cln_ff[g] <= s3_ff[g];
          end
        end
      end
    end
  endgenerate
endmodule

// ==== logic/hs_supervisor.sv ====
// Purpose: Gate drive mode, fault timing and power-good latch of a hot-swap
//          controller, with a classic Wishbone register slave
// Assumes: Comparator levels are asynchronous; trip inputs are high when tripped
// Notes:   Gate mode outputs are one-hot registered drive selects
//
// What this block does
// RL1: Sustained over-current regulates the gate, then switches off after the time-out.
// RL2: Over-current clearing before time-out resumes normal on and resets the timer.
// RL3: High supply trip turns gate off at once until trip clears.
// RL4: Low supply trip turns gate off at once until trip clears.
// RL5: Low supply trip then release clears the latched off state, restarting power-up.
// RL6: Hard fault turns gate off at once, resets timer, allows one retry.
// RL7: Retry that stays clean keeps the gate on; persisting fault latches off.
// RL8: Supply lockout active then inactive also clears the latched off state.
// RL9: Gate drives on from off only with lockout, low, high and over-current all clear; a hard-fault retry checks only lockout, low and high.
// RL10: Only the over-current time-out or a failed hard-fault retry latches the gate off.
// RL11: Weak pull-up to turn on, normal pull-down, strong pull-down for hard faults.
// RL12: Over-current selects regulation mode instead of switching fully off.
// RL13: Power-good sets only when drain is low and gate is full together.
// RL14: Power-good clears on high or low trip, lockout, time-out or power-down.
// RL15: Active-low variant pulls output low while power-good is set.
// RL16: Active-high variant drives low while reset and releases while set.
// RL17: Drain comparator is ignored once power-good is set.
// RL18: Drain comparator never turns the gate off.
// RL19: All comparator inputs synchronised; time-out counted in clock cycles.
// RL20: After reset: gate off, power-good clear, nothing latched, retry available.
`timescale 1ns/10ps
module hs_supervisor
  import hs_sup_pkg::*;
#(
  parameter int OC_TO_CYC = OC_TIMEOUT_CYC,
  parameter int HF_CYC    = HF_OFF_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        supply_lockout_i,
  input  wire logic        low_supply_trip_i,
  input  wire logic        high_supply_trip_i,
  input  wire logic        overcurrent_fault_i,
  input  wire logic        hard_fault_i,
  input  wire logic        drain_low_i,
  input  wire logic        gate_full_i,
  output logic             gate_pullup_o,
  output logic             gate_regulate_o,
  output logic             gate_pd_normal_o,
  output logic             gate_pd_strong_o,
  output logic             supply_ok_out_o,
  output logic             supply_ok_out_oe_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  localparam int TW = $clog2(OC_TO_CYC + 1);
  localparam logic [TW-1:0] TO_LAST = TW'(OC_TO_CYC - 1);
  localparam logic [TW-1:0] HF_LAST = TW'(HF_CYC - 1);

  cmp_sync_if #(.W(N_IN)) cmp ();

  gate_st_t      st_ff;
  gate_st_t      nxt_st;
  logic [TW-1:0] timer_ff;
  logic          retry_used_ff;
  logic          pg_ff;
  logic          pol_high_ff;
  logic          oe_ff;
  logic          gpu_ff;
  logic          greg_ff;
  logic          gpdn_ff;
  logic          gpds_ff;
  logic          ack_ff;
  logic [31:0]   dat_ff;
  logic          lock;
  logic          uv;
  logic          ov;
  logic          oc;
  logic          hf;
  logic          drain_ok;
  logic          gate_ok;
  logic          ok;
  logic          on_like;
  logic          wb_req;

  // RL19 input synchronisers
  assign cmp.raw = {gate_full_i, drain_low_i, hard_fault_i, overcurrent_fault_i,
                    high_supply_trip_i, low_supply_trip_i, supply_lockout_i};

  cmp_sync #(.W(N_IN), .RST(SYNC_RST)) u_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .s      (cmp.sync)
  );

  assign lock     = cmp.cln[IN_LOCK];
  assign uv       = cmp.cln[IN_UV];
  assign ov       = cmp.cln[IN_OV];
  assign oc       = cmp.cln[IN_OC];
  assign hf       = cmp.cln[IN_HF];
  assign drain_ok = cmp.cln[IN_DRAIN];
  assign gate_ok  = cmp.cln[IN_GATE];
  // RL9 supply conditions
  assign ok       = !lock && !uv && !ov;

  function automatic logic is_on(input gate_st_t s);
    return (s == ST_ON) || (s == ST_REG);
  endfunction

  assign on_like = is_on(nxt_st);

  // Gate state decision
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_OFF: begin
        // RL9 all conditions met
        if (ok && !hf && !oc) begin
          nxt_st = ST_ON;
        end
      end
      ST_ON: begin
        // RL6 hard fault wins
        if (hf) begin
          nxt_st = ST_HARD;
        // RL3 RL4 RL8 off while tripped
        end else if (!ok) begin
          nxt_st = ST_OFF;
        // RL12 enter regulation
        end else if (oc) begin
          nxt_st = ST_REG;
        end
      end
      ST_REG: begin
        if (hf) begin
          nxt_st = ST_HARD;
        end else if (!ok) begin
          nxt_st = ST_OFF;
        // RL2 fault gone, resume
        end else if (!oc) begin
          nxt_st = ST_ON;
        // RL1 RL10 time-out latches
        end else if (timer_ff == TO_LAST) begin
          nxt_st = ST_LATCH;
        end
      end
      ST_HARD: begin
        // RL6 RL7 single retry then latch
        if (timer_ff >= HF_LAST) begin
          if (retry_used_ff) begin
            nxt_st = ST_LATCH;
          end else if (ok) begin
            nxt_st = ST_ON;
          end else begin
            nxt_st = ST_OFF;
          end
        end
      end
      ST_LATCH: begin
        // RL5 RL8 latch cleared by low trip or lockout
        if (uv || lock) begin
          nxt_st = ST_OFF;
        end
      end
      default: begin
        nxt_st = ST_OFF;
      end
    endcase
  end

  // RL20 state starts off
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= ST_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // RL1 RL2 RL6 timer restarts on every state change
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer_ff <= '0;
    end else if (st_ff != nxt_st) begin
      timer_ff <= '0;
    end else if (st_ff == ST_REG || st_ff == ST_HARD ||
                 (st_ff == ST_ON && retry_used_ff)) begin
      if (timer_ff != TO_LAST) begin
        timer_ff <= timer_ff + TW'(1);
      end
    end
  end

  // RL7 retry allowance restored after a clean time-out
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      retry_used_ff <= 1'b0;
    end else if (st_ff == ST_HARD && nxt_st == ST_ON) begin
      retry_used_ff <= 1'b1;
    end else if (st_ff == ST_OFF) begin
      retry_used_ff <= 1'b0;
    end else if (st_ff == ST_ON && nxt_st == ST_ON && timer_ff == TO_LAST) begin
      retry_used_ff <= 1'b0;
    end
  end

  // RL11 RL12 drive strength select
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gpu_ff  <= 1'b0;
      greg_ff <= 1'b0;
      gpdn_ff <= 1'b1;
      gpds_ff <= 1'b0;
    end else begin
      gpu_ff  <= (nxt_st == ST_ON);
      greg_ff <= (nxt_st == ST_REG);
      gpdn_ff <= (nxt_st == ST_OFF) || (nxt_st == ST_LATCH);
      gpds_ff <= (nxt_st == ST_HARD);
    end
  end

  assign gate_pullup_o    = gpu_ff;
  assign gate_regulate_o  = greg_ff;
  assign gate_pd_normal_o = gpdn_ff;
  assign gate_pd_strong_o = gpds_ff;

  // Power-good latch
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pg_ff <= 1'b0;
    // RL14 any shut-off clears
    end else if (!on_like) begin
      pg_ff <= 1'b0;
    // RL13 RL17 RL18 drain only read while clear
    end else if (!pg_ff && st_ff == ST_ON && drain_ok && gate_ok) begin
      pg_ff <= 1'b1;
    end
  end

  // RL15 RL16 open-drain polarity
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= pol_high_ff ? !pg_ff : pg_ff;
    end
  end

  assign supply_ok_out_o    = 1'b0;
  assign supply_ok_out_oe_o = oe_ff;

  // Wishbone slave, one wait state
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pol_high_ff <= CTRL_RST;
    end else if (wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == ADR_CTRL) begin
      pol_high_ff <= wb_dat_i[CTRL_POL];
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL:   dat_ff <= {31'h0000_0000, pol_high_ff};
        ADR_STATUS: dat_ff <= {16'h0000, 1'b0, cmp.cln, st_ff, retry_used_ff,
                               oe_ff, pg_ff};
        ADR_TIMER:  dat_ff <= 32'(timer_ff);
        default:    dat_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  property p_reg_hold;
    (st_ff == ST_REG) && oc && ok && !hf && (timer_ff != TO_LAST) |=> gate_regulate_o;
  endproperty
  a_reg_hold: assert property (p_reg_hold) else $error("regulation dropped"); // RL12

  property p_timeout;
    (st_ff == ST_REG) && oc && ok && !hf && (timer_ff == TO_LAST)
      |=> (st_ff == ST_LATCH) ##1 gate_pd_normal_o && !gate_pullup_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no latch at time-out"); // RL1

  property p_resume;
    (st_ff == ST_REG) && !oc && ok && !hf |=> (st_ff == ST_ON) && (timer_ff == '0);
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after fault"); // RL2

  property p_ov_off;
    ov && !hf |=> !gate_pullup_o && !gate_regulate_o;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("gate on during high trip"); // RL3

  property p_uv_off;
    uv && !hf && (st_ff != ST_HARD) |=> gate_pd_normal_o;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("gate on during low trip"); // RL4

  property p_on_cond;
    $rose(gate_pullup_o) |-> $past(ok) && !$past(hf);
  endproperty
  a_on_cond: assert property (p_on_cond) else $error("gate on without conditions"); // RL9

  property p_latch_stays;
    (st_ff == ST_LATCH) && !uv && !lock |=> (st_ff == ST_LATCH);
  endproperty
  a_latch_stays: assert property (p_latch_stays) else $error("latch left early"); // RL10

  property p_hard_strong;
    (st_ff == ST_ON) && hf |=> ##1 gate_pd_strong_o [*2];
  endproperty
  a_hard_strong: assert property (p_hard_strong) else $error("no strong pull-down"); // RL11

  property p_pg_set;
    $rose(pg_ff) |-> $past(drain_ok) && $past(gate_ok);
  endproperty
  a_pg_set: assert property (p_pg_set) else $error("power-good set without cause"); // RL13

  property p_pg_clear;
    pg_ff && (ov || uv || lock) && !hf |=> !pg_ff;
  endproperty
  a_pg_clear: assert property (p_pg_clear) else $error("power-good not cleared"); // RL14

  property p_pg_keep;
    pg_ff && !drain_ok && ok && !oc && !hf && (st_ff == ST_ON) |=> pg_ff && gate_pullup_o;
  endproperty
  a_pg_keep: assert property (p_pg_keep) else $error("drain affected latch or gate"); // RL17

  property p_pol;
    !pol_high_ff ##1 !pol_high_ff |-> supply_ok_out_oe_o == $past(pg_ff);
  endproperty
  a_pol: assert property (p_pol) else $error("active-low output wrong"); // RL15

  c_timeout: cover property ((st_ff == ST_REG) ##1 (st_ff == ST_LATCH));
  c_retry:   cover property ((st_ff == ST_HARD) ##1 (st_ff == ST_ON));
  c_pg:      cover property ($rose(pg_ff));
endmodule

// ==== test/fet_model.sv ====
// Purpose: Behavioural pass transistor and power-module enable pin
// Assumes: Gate charge counted in clock cycles, full charge at 16
// Notes:   slow_i charges the gate four times slower
`timescale 1ns/10ps
module fet_model (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic slow_i,
  input  wire logic pu_i,
  input  wire logic pdn_i,
  input  wire logic pds_i,
  input  wire logic oe_i,
  output logic      gate_full_o,
  output logic      drain_low_o,
  output logic      pin_o
);
  logic [4:0] lvl_ff;
  logic [1:0] div_ff;

  // Regulation mode holds the charge
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_ff <= 5'h00;
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
      if (pds_i) begin
        lvl_ff <= 5'h00;
      end else if (pdn_i && lvl_ff != 5'h00) begin
        lvl_ff <= lvl_ff - 5'h01;
      end else if (pu_i && lvl_ff != 5'h10 && (!slow_i || div_ff == 2'h0)) begin
        lvl_ff <= lvl_ff + 5'h01;
      end
    end
  end

  assign gate_full_o = lvl_ff >= 5'h0E;
  assign drain_low_o = lvl_ff == 5'h10;
  assign pin_o = oe_i ? 1'b0 : 1'b1;
endmodule

// ==== test/tb.sv ====
// Purpose: Self-checking bench of the hot-swap supervisor
// Assumes: Time-out shortened to 200 cycles, hard-fault off time 20
// Notes:   Observed vector is {oe, pullup, regulate, pd_normal, pd_strong}
`timescale 1ns/10ps
module tb;
  import hs_sup_pkg::*;
  localparam int TO = 200;
  localparam int HF = 20;
  localparam int LIMIT = 20000;
  localparam logic [4:0] G_ON = 5'h08;
  localparam logic [4:0] G_REG = 5'h04;
  localparam logic [4:0] G_OFF = 5'h02;
  localparam logic [4:0] G_HARD = 5'h01;
  localparam logic [4:0] TRIPS [3] = '{5'h04, 5'h02, 5'h01};

  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  pins = 5'h01;
  logic        drn_kill = 1'b0;
  logic        slow = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        pu, rg, pdn, pds, oe, full, drn, pin;
  logic        od;
  logic [4:0]  obs;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc_cnt = 0;

  assign obs = {oe, pu, rg, pdn, pds};

  always #2.5 mclk = ~mclk;

  hs_supervisor #(.OC_TO_CYC(TO), .HF_CYC(HF)) hs_supervisor_i (
    .mclk_i(mclk), .rstn_i(rstn), .supply_lockout_i(pins[0]), .low_supply_trip_i(pins[1]),
    .high_supply_trip_i(pins[2]), .overcurrent_fault_i(pins[3]), .hard_fault_i(pins[4]),
    .drain_low_i(drn & ~drn_kill), .gate_full_i(full), .gate_pullup_o(pu),
    .gate_regulate_o(rg), .gate_pd_normal_o(pdn), .gate_pd_strong_o(pds),
    .supply_ok_out_o(od), .supply_ok_out_oe_o(oe), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack));

  fet_model fet_model_i (
    .mclk_i(mclk), .rstn_i(rstn), .slow_i(slow), .pu_i(pu), .pdn_i(pdn), .pds_i(pds),
    .oe_i(oe), .gate_full_o(full), .drain_low_o(drn), .pin_o(pin));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, 4'hF};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'h0;
    chk(32'(n), 32'h2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic pins_to(input logic [4:0] v);
    @(posedge mclk);
    pins <= v;
  endtask

  task automatic wait_obs(input logic [4:0] m, input logic [4:0] e, input int lim,
                          output int n);
    n = 0;
    while ((obs & m) !== e && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk({27'h0, obs & m}, {27'h0, e});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic note(input string s);
    $display("test done: %s", s);
  endtask

  always @(posedge mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    int n;
    logic [31:0] q;
    idle(10);
    rstn <= 1'b1;
    @(posedge mclk);
    chk({27'h0, obs}, {27'h0, G_OFF});
    chk({31'h0, od}, 32'h0);
    rd(ADR_STATUS, 32'hFF, 32'h08);
    rd(ADR_CTRL, 32'h1, 32'h0);
    wb(1'b1, 8'h0C, 32'hFFFFFFFF, q);
    rd(8'h0C, 32'hFFFFFFFF, 32'h0);
    idle(20);
    chk({27'h0, obs}, {27'h0, G_OFF});
    note("reset and registers");
    pins_to(5'h00);
    wait_obs(5'h0F, G_ON, 40, n);
    wait_obs(5'h10, 5'h10, 80, n);
    rd(ADR_STATUS, 32'hFF, 32'h13);
    wb(1'b1, ADR_CTRL, 32'h1, q);
    wait_obs(5'h10, 5'h00, 5, n);
    wb(1'b1, ADR_CTRL, 32'h0, q);
    wait_obs(5'h10, 5'h10, 5, n);
    drn_kill <= 1'b1;
    idle(20);
    chk({27'h0, obs}, {27'h0, 5'h10 | G_ON});
    drn_kill <= 1'b0;
    note("power-up and polarity");
    slow <= 1'b1;
    foreach (TRIPS[i]) begin
      pins_to(TRIPS[i]);
      wait_obs(5'h0F, G_OFF, 10, n);
      wait_obs(5'h10, 5'h00, 10, n);
      pins_to(5'h00);
      wait_obs(5'h0F, G_ON, 40, n);
      wait_obs(5'h10, 5'h10, 120, n);
    end
    slow <= 1'b0;
    note("supply trips");
    pins_to(5'h08);
    wait_obs(5'h0F, G_REG, 10, n);
    idle(TO / 2);
    chk({27'h0, obs}, {27'h0, 5'h10 | G_REG});
    pins_to(5'h00);
    wait_obs(5'h0F, G_ON, 10, n);
    pins_to(5'h08);
    wait_obs(5'h0F, G_REG, 10, n);
    wait_obs(5'h0F, G_OFF, TO + 20, n);
    chk(32'(n >= TO - 3 && n <= TO + 3), 32'h1);
    rd(ADR_STATUS, 32'hFB, 32'h80);
    pins_to(5'h00);
    idle(40);
    chk({27'h0, obs}, {27'h0, G_OFF});
    drn_kill <= 1'b1;
    pins_to(5'h02);
    idle(10);
    pins_to(5'h00);
    wait_obs(5'h0F, G_ON, 40, n);
    idle(40);
    chk({31'h0, pin}, 32'h1);
    drn_kill <= 1'b0;
    wait_obs(5'h10, 5'h10, 40, n);
    pins_to(5'h08);
    wait_obs(5'h0F, G_OFF, TO + 40, n);
    pins_to(5'h01);
    idle(10);
    pins_to(5'h00);
    wait_obs(5'h0F, G_ON, 40, n);
    note("over-current time-out and latch clearing");
    pins_to(5'h08);
    wait_obs(5'h0F, G_REG, 10, n);
    idle(20);
    pins_to(5'h18);
    wait_obs(5'h0F, G_HARD, 10, n);
    rd(ADR_TIMER, 32'hFFFFFFFF, 32'h2);
    pins_to(5'h00);
    wait_obs(5'h0F, G_ON, HF + 40, n);
    rd(ADR_STATUS, 32'h4, 32'h4);
    pins_to(5'h10);
    wait_obs(5'h0F, G_HARD, 10, n);
    idle(8);
    pins_to(5'h00);
    wait_obs(5'h0F, G_OFF, HF + 40, n);
    rd(ADR_STATUS, 32'hF8, 32'h80);
    note("hard fault retry");
    end_of_test();
  end
endmodule
